// ### hw/adcphp_pkg.sv
// Constants shared by the parallel host port of the 12-bit converter.
// Assumes one 125 MHz system clock and pins that arrive asynchronously.
//
// Contract
// - Byte select high shows four result MSBs, low shows eight LSBs.
// - Low four data lines carry bits 0..3 or 8..11 in same order.
// - Completion flag goes low when conversion finished and result ready.
// - Chip select low plus read strobe fall starts driving selected byte.
// - Internal acquisition: write rise latches byte, acquires, converts.
// - External acquisition: next write rise with acquisition bit clear ends acquisition, converts.
// - Chip select high keeps all eight data outputs undriven.
// - Completion flag returns high on first read or on a new write.
// - Every conversion lasts thirteen conversion clock cycles.
// - After power-up the external clock mode is in use.
// - A write during conversion aborts it and starts a new acquisition.
package adcphp_pkg;

   // ==========================================================
   // Widths
   localparam int RESULT_W     = 12;
   localparam int DATA_W       = 8;
   localparam int TICK_CNT_W   = 4;

   // ==========================================================
   // Control byte fields
   localparam int ACQ_SEL_BIT  = 5;
   localparam int CLK_SEL_BIT  = 6;

   // ==========================================================
   // Cycle counts, in conversion clock ticks
   localparam logic [TICK_CNT_W-1:0] CONV_TICKS = 4'hd;
   localparam logic [TICK_CNT_W-1:0] ACQ_TICKS  = 4'h3;

   // ==========================================================
   // Internal oscillator, derived from the system clock
   localparam int SYS_CLK_MHZ  = 125;
   localparam int OSC_MHZ      = 7;
   localparam int OSC_DIV      = SYS_CLK_MHZ / OSC_MHZ;
   localparam int OSC_CNT_W    = 5;

   // ==========================================================
   // Reset values
   localparam logic [DATA_W-1:0]   CFG_RESET    = 8'h00;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;

   typedef enum logic [1:0] {
      ADCPHP_IDLE    = 2'b00,
      ADCPHP_ACQ_INT = 2'b01,
      ADCPHP_ACQ_EXT = 2'b10,
      ADCPHP_CONV    = 2'b11
   } adcphp_state_t;

endpackage

// ### hw/adcphp_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes its inputs are levels that are stable for several clocks.
module adcphp_sync
   import adcphp_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// ### hw/adcphp_host_port.sv
// Byte-wide host port: control byte write, two-half result read,
// completion flag and conversion sequencing.
// Assumes a converter core supplies its 12-bit code on sample_code_in,
// in the system clock domain; every pin is asynchronous.
module adcphp_host_port
   import adcphp_pkg::*;
(
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                rst_b_in,
   // Host strobes and pins
   input  wire logic                chip_select_b_in,
   input  wire logic                read_strobe_b_in,
   input  wire logic                write_strobe_b_in,
   input  wire logic                byte_half_select_in,
   input  wire logic                conv_clk_pin_in,
   // Data bus, split into input, output and enable
   input  wire logic [DATA_W-1:0]   data_in,
   output logic      [DATA_W-1:0]   data_out,
   output logic                     data_oe_out,
   // Completion flag
   output logic                     done_b_out,
   // Converter core
   input  wire logic [RESULT_W-1:0] sample_code_in,
   output logic      [DATA_W-1:0]   config_byte_out,
   output logic                     hold_out
);

   // ==========================================================
   // Pin synchronisation
   localparam int SYNC_W = DATA_W + 5;

   logic [SYNC_W-1:0] pins_s;
   logic              cs_b_s;
   logic              rd_b_s;
   logic              wr_b_s;
   logic              byte_half_select_s;
   logic              cclk_s;
   logic [DATA_W-1:0] data_s;

   adcphp_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .async_in ({chip_select_b_in, read_strobe_b_in, write_strobe_b_in,
                  byte_half_select_in, conv_clk_pin_in, data_in}),
      .sync_out (pins_s)
   );

   assign cs_b_s = pins_s[SYNC_W-1];
   assign rd_b_s = pins_s[SYNC_W-2];
   assign wr_b_s = pins_s[SYNC_W-3];
   assign byte_half_select_s = pins_s[SYNC_W-4];
   assign cclk_s = pins_s[SYNC_W-5];
   assign data_s = pins_s[DATA_W-1:0];

   // ==========================================================
   // Edge detection on synchronised levels
   logic rd_prev_q;
   logic rd_prev_d;
   logic wr_prev_q;
   logic wr_prev_d;
   logic cclk_prev_q;
   logic cclk_prev_d;
   logic read_fall;
   logic write_rise;
   logic ext_tick;

   always_comb
   begin
      rd_prev_d   = rd_b_s;
      wr_prev_d   = wr_b_s;
      cclk_prev_d = cclk_s;
      read_fall   = rd_prev_q && !rd_b_s && !cs_b_s;
      write_rise  = !wr_prev_q && wr_b_s && !cs_b_s;
      ext_tick    = cclk_prev_q && !cclk_s;
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         rd_prev_q   <= 1'b1;
         wr_prev_q   <= 1'b1;
         cclk_prev_q <= 1'b0;
      end
      else
      begin
         rd_prev_q   <= rd_prev_d;
         wr_prev_q   <= wr_prev_d;
         cclk_prev_q <= cclk_prev_d;
      end
   end

   // ==========================================================
   // Conversion clock source
   // The pin is only trusted in external mode; a tied pin gives no ticks.
   logic [OSC_CNT_W-1:0] osc_cnt_q;
   logic [OSC_CNT_W-1:0] osc_cnt_d;
   logic                 osc_tick;
   logic                 tick;
   logic [DATA_W-1:0]    cfg_q;
   logic [DATA_W-1:0]    cfg_d;

   always_comb
   begin
      osc_tick = (osc_cnt_q == OSC_CNT_W'(OSC_DIV - 1));
      osc_cnt_d = osc_tick ? '0 : osc_cnt_q + 1'b1;
      tick = cfg_q[CLK_SEL_BIT] ? osc_tick : ext_tick;
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         osc_cnt_q <= '0;
      end
      else
      begin
         osc_cnt_q <= osc_cnt_d;
      end
   end

   // ==========================================================
   // Acquisition and conversion sequencer
   adcphp_state_t          state_q;
   adcphp_state_t          state_d;
   logic [TICK_CNT_W-1:0]  tick_cnt_q;
   logic [TICK_CNT_W-1:0]  tick_cnt_d;
   logic [RESULT_W-1:0]    result_q;
   logic [RESULT_W-1:0]    result_d;
   logic                   done_b_q;
   logic                   done_b_d;
   logic                   hold_q;
   logic                   hold_d;
   logic                   conv_end;

   always_comb
   begin
      state_d    = state_q;
      tick_cnt_d = tick_cnt_q;
      cfg_d      = cfg_q;
      result_d   = result_q;
      done_b_d   = done_b_q;
      conv_end   = 1'b0;
      unique case (state_q)
         ADCPHP_IDLE:
         begin
         end
         ADCPHP_ACQ_INT:
         begin
            if (tick)
            begin
               tick_cnt_d = tick_cnt_q + 1'b1;
               if (tick_cnt_q == ACQ_TICKS - 1'b1)
               begin
                  state_d    = ADCPHP_CONV;
                  tick_cnt_d = '0;
               end
            end
         end
         ADCPHP_ACQ_EXT:
         begin
         end
         ADCPHP_CONV:
         begin
            if (tick)
            begin
               tick_cnt_d = tick_cnt_q + 1'b1;
               if (tick_cnt_q == CONV_TICKS - 1'b1)
               begin
                  conv_end   = 1'b1;
                  state_d    = ADCPHP_IDLE;
                  tick_cnt_d = '0;
                  result_d   = sample_code_in;
               end
            end
         end
      endcase
      if (read_fall)
      begin
         done_b_d = 1'b1;
      end
      if (write_rise)
      begin
         cfg_d      = data_s;
         done_b_d   = 1'b1;
         tick_cnt_d = '0;
         if (data_s[ACQ_SEL_BIT])
         begin
            state_d = ADCPHP_ACQ_EXT;
         end
         else if (state_q == ADCPHP_ACQ_EXT)
         begin
            state_d = ADCPHP_CONV;
         end
         else
         begin
            // A write mid-conversion with the acquisition bit clear lands here too and restarts.
            state_d = ADCPHP_ACQ_INT;
         end
      end
      else if (conv_end)
      begin
         done_b_d = 1'b0;
      end
      // Completion outranks a same-cycle read so no result goes unflagged.
      if (conv_end && !write_rise)
      begin
         done_b_d = 1'b0;
      end
      hold_d = (state_d == ADCPHP_CONV);
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_q    <= ADCPHP_IDLE;
         tick_cnt_q <= '0;
         cfg_q      <= CFG_RESET;
         result_q   <= RESULT_RESET;
         done_b_q   <= 1'b1;
         hold_q     <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         tick_cnt_q <= tick_cnt_d;
         cfg_q      <= cfg_d;
         result_q   <= result_d;
         done_b_q   <= done_b_d;
         hold_q     <= hold_d;
      end
   end

   // ==========================================================
   // Read data path
   logic [DATA_W-1:0] rd_data_q;
   logic [DATA_W-1:0] rd_data_d;
   logic              oe_q;
   logic              oe_d;

   always_comb
   begin
      if (byte_half_select_s)
      begin
         rd_data_d = {4'h0, result_q[RESULT_W-1:DATA_W]};
      end
      else
      begin
         rd_data_d = result_q[DATA_W-1:0];
      end
      // Drive begins on the read fall and persists while strobes stay low.
      oe_d = !cs_b_s && !rd_b_s && (read_fall || oe_q);
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         rd_data_q <= '0;
         oe_q      <= 1'b0;
      end
      else
      begin
         rd_data_q <= rd_data_d;
         oe_q      <= oe_d;
      end
   end

   assign data_out        = rd_data_q;
   assign data_oe_out     = oe_q;
   assign done_b_out      = done_b_q;
   assign config_byte_out = cfg_q;
   assign hold_out        = hold_q;

endmodule

// ### testbench/adcphp_asserts.sv
// Checker for the host port, bound to the top module's ports.
// Assumes the host holds its pins several clocks around each strobe.
module adcphp_asserts
   import adcphp_pkg::*;
(
   input wire logic              clk_in,
   input wire logic              rst_b_in,
   input wire logic              chip_select_b_in,
   input wire logic              read_strobe_b_in,
   input wire logic              byte_half_select_in,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              data_oe_out,
   input wire logic              done_b_out,
   input wire logic [DATA_W-1:0] config_byte_out,
   input wire logic              hold_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // Thirteen ticks of at least 17 clocks each, with some slack.
   localparam int CONV_MIN = 200;
   logic [8:0] run_q;
   logic [8:0] run_d;
   logic       prev_q;
   always_comb
   begin
      run_d = run_q;
      if (hold_out && !prev_q)
         run_d = 9'h001;
      else if (hold_out && run_q != 9'h1ff)
         run_d = run_q + 9'h001;
   end
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         run_q <= 9'h000;
         prev_q <= 1'b0;
      end
      else
      begin
         run_q <= run_d;
         prev_q <= hold_out;
      end
   end
   // ==========
   // Properties
   sequence s_read_req;
      !chip_select_b_in && !read_strobe_b_in;
   endsequence
   sequence s_high_read;
      (data_oe_out && byte_half_select_in) [*5];
   endsequence
   a_bus_float_cs: assert property (
      chip_select_b_in [*5] |-> !data_oe_out)
      else $error("bus driven with chip select high");
   a_read_opens_bus: assert property (
      s_read_req [*6] |-> data_oe_out)
      else $error("read did not drive the bus");
   a_oe_has_cause: assert property ($rose(data_oe_out) |->
      $past(chip_select_b_in, 3) == 1'b0 &&
      $past(read_strobe_b_in, 3) == 1'b0)
      else $error("bus driven without a read");
   a_high_half_zero: assert property (
      s_high_read |-> data_out[7:4] == 4'h0)
      else $error("upper lines not zero in high half");
   a_done_needs_host: assert property ($rose(done_b_out) |->
      $past(chip_select_b_in, 3) == 1'b0)
      else $error("flag cleared without host access");
   a_conv_full_len: assert property (
      $fell(done_b_out) |-> run_q >= CONV_MIN)
      else $error("conversion too short");
   a_cfg_from_write: assert property ($changed(config_byte_out) |->
      $past(chip_select_b_in, 4) == 1'b0)
      else $error("control byte changed without select");
   a_cfg_clears_done: assert property (
      $changed(config_byte_out) |-> done_b_out)
      else $error("write left the flag low");
   a_hold_done_excl: assert property (hold_out |-> done_b_out)
      else $error("flag low while converting");
endmodule

bind adcphp_host_port adcphp_asserts i_chk (.clk_in, .rst_b_in,
   .chip_select_b_in, .read_strobe_b_in, .byte_half_select_in, .data_out,
   .data_oe_out, .done_b_out, .config_byte_out, .hold_out);

// ### testbench/adcphp_host_model.sv
// Host processor model: strobes, conversion clock and the shared bus.
// Assumes one system clock; all pins change just after a rising edge.
module adcphp_host_model
   import adcphp_pkg::*;
(
   // Clock and device outputs
   input  wire logic              clk_in,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic              data_oe_out,
   // Host pins
   output logic                   cs_b_out,
   output logic                   rd_b_out,
   output logic                   wr_b_out,
   output logic                   half_out,
   output logic                   cclk_out,
   output logic      [DATA_W-1:0] bus_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] drv_q = 8'h00;
   logic [7:0] last_q = 8'h00;
   logic       drv_en = 1'b0;
   logic       ext_q = 1'b1;
   logic [3:0] div_q = 4'h0;
   initial
   begin
      cs_b_out = 1'b1;
      rd_b_out = 1'b1;
      wr_b_out = 1'b1;
      half_out = 1'b0;
      cclk_out = 1'b1;
   end
   // A floating bus shows the inverse of its last driven level.
   assign bus_out = data_oe_out ? data_out : (drv_en ? drv_q : ~last_q);
   always @(posedge clk_in)
   begin
      if (drv_en || data_oe_out)
         last_q <= bus_out;
      div_q <= (div_q == 4'h8) ? 4'h0 : div_q + 4'h1;
      if (div_q == 4'h8)
         cclk_out <= ext_q ? ~cclk_out : 1'b1;
   end
   // ==========
   // Bus cycles
   task automatic wr(input logic [7:0] b);
      @(posedge clk_in);
      cs_b_out <= 1'b0;
      wr_b_out <= 1'b0;
      drv_q <= b;
      drv_en <= 1'b1;
      repeat (8) @(posedge clk_in);
      wr_b_out <= 1'b1;
      ext_q <= !b[CLK_SEL_BIT];
      repeat (6) @(posedge clk_in);
      cs_b_out <= 1'b1;
      drv_en <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask
   task automatic rd(input logic cs_b, input logic h,
                     output logic [7:0] v, output logic oe);
      @(posedge clk_in);
      cs_b_out <= cs_b;
      half_out <= h;
      rd_b_out <= 1'b0;
      repeat (7) @(posedge clk_in);
      v = data_out;
      oe = data_oe_out;
      rd_b_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      cs_b_out <= 1'b1;
      repeat (6) @(posedge clk_in);
   endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the host port with the host model beside it.
// Assumes the bench plays the converter core on sample_code_in.
module testbench
   import adcphp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          clk_in = 1'b0;
   logic          rst_b_in = 1'b0;
   logic [11:0]   code = 12'ha5c;
   wire logic       cs_b, rd_b, wr_b, half, cclk;
   wire logic       oe, done_b, hold;
   wire logic [7:0] bus, dout, cfg;
   int            bad_count = 0;
   int            compares = 0;
   int            cycles = 0;
   always #4 clk_in = ~clk_in;
   adcphp_host_port i_adcphp_host_port (.clk_in, .rst_b_in,
      .chip_select_b_in(cs_b), .read_strobe_b_in(rd_b),
      .write_strobe_b_in(wr_b), .byte_half_select_in(half),
      .conv_clk_pin_in(cclk), .data_in(bus), .data_out(dout),
      .data_oe_out(oe), .done_b_out(done_b), .sample_code_in(code),
      .config_byte_out(cfg), .hold_out(hold));
   adcphp_host_model i_host (.clk_in, .data_out(dout), .data_oe_out(oe),
      .cs_b_out(cs_b), .rd_b_out(rd_b), .wr_b_out(wr_b),
      .half_out(half), .cclk_out(cclk), .bus_out(bus));
   // ==========
   // Helpers
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Bounded waits keep a stuck flag from hanging the run.
   task automatic wait_for(input logic want_hold, input int n);
      while ((want_hold ? hold !== 1'b1 : done_b !== 1'b0) && n > 0)
      begin
         @(posedge clk_in);
         n--;
      end
   endtask
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         end_sim();
      end
   end
   // ==========
   // Scenarios
   task automatic t_internal();
      logic [7:0] v;
      logic       o;
      i_host.wr(8'h1f);
      chk(cfg, 8'h1f);
      wait_for(1'b0, 600);
      chk(done_b, 1'b0);
      i_host.rd(1'b0, 1'b0, v, o);
      chk(v, 8'h5c);
      chk(o, 1'b1);
      chk(done_b, 1'b1);
      code <= 12'h3c1;
      i_host.rd(1'b0, 1'b1, v, o);
      chk(v, 8'h0a);
      i_host.rd(1'b0, 1'b0, v, o);
      chk(v, 8'h5c);
      i_host.rd(1'b1, 1'b0, v, o);
      chk(o, 1'b0);
   endtask
   task automatic t_external();
      logic [7:0] v;
      logic       o;
      i_host.wr(8'h20);
      repeat (600) @(posedge clk_in);
      chk({done_b, hold}, 2'b10);
      i_host.wr(8'h00);
      chk(hold, 1'b1);
      wait_for(1'b0, 400);
      i_host.rd(1'b0, 1'b0, v, o);
      chk(v, 8'hc1);
   endtask
   task automatic t_abort();
      logic [7:0] v;
      logic       o;
      code <= 12'h7e4;
      i_host.wr(8'h00);
      wait_for(1'b1, 200);
      repeat (40) @(posedge clk_in);
      i_host.wr(8'h00);
      chk({done_b, hold}, 2'b10);
      wait_for(1'b0, 600);
      chk(done_b, 1'b0);
      i_host.rd(1'b0, 1'b1, v, o);
      chk(v, 8'h07);
   endtask
   task automatic t_int_osc();
      i_host.wr(8'h40);
      wait_for(1'b0, 600);
      chk(done_b, 1'b0);
      i_host.wr(8'h40);
      chk(done_b, 1'b1);
      i_host.wr(8'h60);
      chk({done_b, hold}, 2'b10);
      i_host.wr(8'h40);
      chk(hold, 1'b1);
      wait_for(1'b0, 600);
      chk(done_b, 1'b0);
   endtask
   initial
   begin
      repeat (5) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk({oe, done_b, hold, cfg}, 11'h200);
      t_internal();
      t_external();
      t_abort();
      t_int_osc();
      end_sim();
   end
endmodule
